// ==== design/gsr_pkg.sv ====
// package: constants, register selects and carriers of the status reporting block
package gsr_pkg;

  localparam int REG_W = 16;

  // register selects of the command port
  typedef enum logic [2:0] {
    GSR_SEL_STD_EVENT = 3'h0,
    GSR_SEL_STD_MASK = 3'h1,
    GSR_SEL_OPER_COND = 3'h2,
    GSR_SEL_RISE_FILT = 3'h3,
    GSR_SEL_FALL_FILT = 3'h4,
    GSR_SEL_OPER_EVENT = 3'h5,
    GSR_SEL_OPER_MASK = 3'h6
  } gsr_sel_t;

  // field positions
  localparam int STD_UNUSED_BIT = 1;
  localparam int STD_QUERY_FAULT_BIT = 2;
  localparam int OPER_TRIG_BIT = 5;
  localparam int OPER_ARM_BIT = 6;
  localparam int OPER_CALC_BIT = 9;

  // reset and preset values, and the mask of used standard event bits
  localparam logic [15:0] STD_EVENT_RST = 16'h0000;
  localparam logic [15:0] STD_MASK_RST = 16'h0000;
  localparam logic [15:0] RISE_FILT_RST = 16'hffff;
  localparam logic [15:0] FALL_FILT_RST = 16'h0000;
  localparam logic [15:0] OPER_EVENT_RST = 16'h0000;
  localparam logic [15:0] OPER_MASK_RST = 16'h0000;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [15:0] STD_USED_BITS = 16'hfffd;

  // decoded interface messages, one-cycle pulses except ren
  typedef struct packed {
    logic ren;
    logic ifc;
    logic mla;
    logic mta;
    logic unl;
    logic unt;
    logic llo;
  } gsr_bus_msg_t;

  // register access from the command parser
  typedef struct packed {
    logic wr;
    logic rd;
    gsr_sel_t sel;
    logic [15:0] wdata;
    logic cls;
    logic preset;
  } gsr_reg_cmd_t;

  // whole state of the block
  typedef struct packed {
    logic remote;
    logic lockout;
    logic talker;
    logic listener;
    logic srq_lit;
    logic restore;
    logic [15:0] std_event;
    logic [15:0] std_mask;
    logic [15:0] cond_prev;
    logic [15:0] rise_filt;
    logic [15:0] fall_filt;
    logic [15:0] oper_event;
    logic [15:0] oper_mask;
    logic evt_sum;
    logic op_sum;
    logic [15:0] rdata;
    logic rvalid;
  } gsr_state_t;

endpackage : gsr_pkg

// ==== design/gsr_status.sv ====
// status reporting: interface state lamps, local key, standard and operation event sets
`timescale 1ns/1ps

module gsr_status (
  input wire logic mclk, // 20 MHz instrument clock
  input wire logic nrst, // asynchronous reset, active low
  input wire gsr_pkg::gsr_bus_msg_t bus_msg, // decoded interface messages
  input wire logic [7:0] panel_keys, // front panel key strobes, local excluded
  input wire logic local_key, // local key strobe
  input wire logic srq_raised, // service request generated, pulse
  input wire logic srq_causes, // any cause of the request still present
  input wire logic spoll_read, // serial poll byte read, pulse
  input wire logic [15:0] std_event_in, // standard event strobes
  input wire logic empty_queue_read, // read attempt on empty output queue
  input wire logic [15:0] oper_cond_in, // direct operating conditions
  input wire logic trig_summary, // trigger layer summary
  input wire logic arm_summary, // arm layer summary
  input wire gsr_pkg::gsr_reg_cmd_t reg_cmd, // register access command
  output logic host_control_lamp, // remote annunciator
  output logic talk_lamp, // talker annunciator
  output logic listener_lamp, // listener annunciator
  output logic srq_lamp, // service request annunciator
  output logic [7:0] panel_keys_out, // keys let through to the panel logic
  output logic display_restore, // return display to normal, pulse
  output logic query_fault_flag, // standard event bit two
  output logic event_summary_flag, // standard summary to status byte
  output logic operation_summary_flag, // operation summary to status byte
  output logic [15:0] operation_condition_live, // live condition word
  output logic [15:0] rdata, // read data, registered
  output logic rvalid // read data valid, pulse
);

  ////////////////////////////////////////////////////////////////////////////////
  // state and decode

  gsr_pkg::gsr_state_t st_reg;
  gsr_pkg::gsr_state_t st_next;
  logic [15:0] cond_now;
  logic [15:0] oper_hits;
  logic [15:0] std_hits;
  logic rd_std;
  logic rd_oper;
  logic local_ok;

  // live condition word with layer summaries spliced in
  always_comb begin
    cond_now = oper_cond_in;
    cond_now[gsr_pkg::OPER_TRIG_BIT] = trig_summary;
    cond_now[gsr_pkg::OPER_ARM_BIT] = arm_summary;
  end

  assign oper_hits = (cond_now & ~st_reg.cond_prev & st_reg.rise_filt)
    | (~cond_now & st_reg.cond_prev & st_reg.fall_filt);

  assign std_hits = (std_event_in
    | ({15'h0000, empty_queue_read} << gsr_pkg::STD_QUERY_FAULT_BIT))
    & gsr_pkg::STD_USED_BITS;

  assign rd_std = reg_cmd.rd && (reg_cmd.sel == gsr_pkg::GSR_SEL_STD_EVENT);
  assign rd_oper = reg_cmd.rd && (reg_cmd.sel == gsr_pkg::GSR_SEL_OPER_EVENT);

  assign local_ok = local_key && !st_reg.lockout;

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_next = st_reg;
    st_next.restore = 1'b0;
    st_next.rvalid = 1'b0;

    // lockout held until ren falls
    if (!bus_msg.ren) begin
      st_next.lockout = 1'b0;
    end else if (bus_msg.llo) begin
      st_next.lockout = 1'b1;
    end

    if (!bus_msg.ren || local_ok) begin
      st_next.remote = 1'b0;
    end else if (bus_msg.mla) begin
      st_next.remote = 1'b1;
    end
    st_next.restore = local_ok;

    if (bus_msg.ifc || bus_msg.unt || bus_msg.mla) begin
      st_next.talker = 1'b0;
    end else if (bus_msg.mta) begin
      st_next.talker = 1'b1;
    end

    if (bus_msg.ifc || bus_msg.unl || bus_msg.mta) begin
      st_next.listener = 1'b0;
    end else if (bus_msg.mla) begin
      st_next.listener = 1'b1;
    end

    if (srq_raised) begin
      st_next.srq_lit = 1'b1;
    end else if (spoll_read || !srq_causes) begin
      st_next.srq_lit = 1'b0;
    end

    if (reg_cmd.cls || rd_std) begin
      st_next.std_event = std_hits;
    end else begin
      st_next.std_event = st_reg.std_event | std_hits;
    end

    if (reg_cmd.cls || rd_oper) begin
      st_next.oper_event = oper_hits;
    end else begin
      st_next.oper_event = st_reg.oper_event | oper_hits;
    end
    st_next.cond_prev = cond_now;

    if (reg_cmd.wr) begin
      unique case (reg_cmd.sel)
        gsr_pkg::GSR_SEL_STD_MASK: st_next.std_mask = reg_cmd.wdata;
        gsr_pkg::GSR_SEL_RISE_FILT: st_next.rise_filt = reg_cmd.wdata;
        gsr_pkg::GSR_SEL_FALL_FILT: st_next.fall_filt = reg_cmd.wdata;
        gsr_pkg::GSR_SEL_OPER_MASK: st_next.oper_mask = reg_cmd.wdata;
        default: st_next.std_mask = st_reg.std_mask;
      endcase
    end

    if (reg_cmd.preset) begin
      st_next.rise_filt = gsr_pkg::RISE_FILT_RST;
      st_next.fall_filt = gsr_pkg::FALL_FILT_RST;
      st_next.oper_mask = gsr_pkg::OPER_MASK_RST;
    end

    st_next.evt_sum = |(st_next.std_event & st_next.std_mask);
    st_next.op_sum = |(st_next.oper_event & st_next.oper_mask);

    if (reg_cmd.rd) begin
      st_next.rvalid = 1'b1;
      unique case (reg_cmd.sel)
        gsr_pkg::GSR_SEL_STD_EVENT: st_next.rdata = st_reg.std_event;
        gsr_pkg::GSR_SEL_STD_MASK: st_next.rdata = st_reg.std_mask;
        gsr_pkg::GSR_SEL_OPER_COND: st_next.rdata = cond_now;
        gsr_pkg::GSR_SEL_RISE_FILT: st_next.rdata = st_reg.rise_filt;
        gsr_pkg::GSR_SEL_FALL_FILT: st_next.rdata = st_reg.fall_filt;
        gsr_pkg::GSR_SEL_OPER_EVENT: st_next.rdata = st_reg.oper_event;
        gsr_pkg::GSR_SEL_OPER_MASK: st_next.rdata = st_reg.oper_mask;
        default: st_next.rdata = gsr_pkg::ZERO_WORD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  // power-up values of every field
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '{
        remote: 1'b0, lockout: 1'b0, talker: 1'b0, listener: 1'b0,
        srq_lit: 1'b0, restore: 1'b0,
        std_event: gsr_pkg::STD_EVENT_RST, std_mask: gsr_pkg::STD_MASK_RST,
        cond_prev: gsr_pkg::ZERO_WORD,
        rise_filt: gsr_pkg::RISE_FILT_RST, fall_filt: gsr_pkg::FALL_FILT_RST,
        oper_event: gsr_pkg::OPER_EVENT_RST, oper_mask: gsr_pkg::OPER_MASK_RST,
        evt_sum: 1'b0, op_sum: 1'b0, rdata: gsr_pkg::ZERO_WORD, rvalid: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  // lamps, flags and read data straight from state, live condition word from the inputs
  assign host_control_lamp = st_reg.remote;
  assign talk_lamp = st_reg.talker;
  assign listener_lamp = st_reg.listener;
  assign srq_lamp = st_reg.srq_lit;
  assign display_restore = st_reg.restore;
  assign query_fault_flag = st_reg.std_event[gsr_pkg::STD_QUERY_FAULT_BIT];
  assign event_summary_flag = st_reg.evt_sum;
  assign operation_summary_flag = st_reg.op_sum;
  assign operation_condition_live = cond_now;
  assign rdata = st_reg.rdata;
  assign rvalid = st_reg.rvalid;

  assign panel_keys_out = st_reg.remote ? 8'h00 : panel_keys;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  property p_remote_needs_ren;
    $rose(host_control_lamp) |-> $past(bus_msg.ren) && $past(bus_msg.mla);
  endproperty
  a_remote_needs_ren: assert property (p_remote_needs_ren)
    else $error("remote entered without listen address and ren");

  property p_keys_locked;
    host_control_lamp |-> panel_keys_out == 8'h00;
  endproperty
  a_keys_locked: assert property (p_keys_locked)
    else $error("panel key passed while remote");

  property p_talk_on;
    bus_msg.mta && !bus_msg.ifc && !bus_msg.unt && !bus_msg.mla |=> talk_lamp && !listener_lamp;
  endproperty
  a_talk_on: assert property (p_talk_on)
    else $error("talk address did not make talker active");

  property p_talk_off;
    bus_msg.ifc || bus_msg.unt || bus_msg.mla |=> !talk_lamp;
  endproperty
  a_talk_off: assert property (p_talk_off)
    else $error("talker not idled");

  property p_listen_off;
    bus_msg.ifc || bus_msg.unl || bus_msg.mta |=> !listener_lamp;
  endproperty
  a_listen_off: assert property (p_listen_off)
    else $error("listener not idled");

  property p_srq_hold;
    srq_lamp && !spoll_read && srq_causes |=> srq_lamp;
  endproperty
  a_srq_hold: assert property (p_srq_hold)
    else $error("srq lamp dropped early");

  property p_local_lockout;
    st_reg.lockout && host_control_lamp && bus_msg.ren |=> host_control_lamp;
  endproperty
  a_local_lockout: assert property (p_local_lockout)
    else $error("remote lost under lockout");

  property p_local_cancel;
    local_key && !st_reg.lockout |=> !host_control_lamp && display_restore;
  endproperty
  a_local_cancel: assert property (p_local_cancel)
    else $error("local key did not cancel remote");

  property p_bit_one_clear;
    st_reg.std_event[gsr_pkg::STD_UNUSED_BIT] == 1'b0;
  endproperty
  a_bit_one_clear: assert property (p_bit_one_clear)
    else $error("unused standard bit set");

  property p_query_fault;
    empty_queue_read |=> query_fault_flag;
  endproperty
  a_query_fault: assert property (p_query_fault)
    else $error("query fault not latched");

  property p_event_summary;
    ##1 event_summary_flag == |(st_reg.std_event & st_reg.std_mask);
  endproperty
  a_event_summary: assert property (p_event_summary)
    else $error("event summary wrong");

  property p_oper_summary;
    ##1 operation_summary_flag == |(st_reg.oper_event & st_reg.oper_mask);
  endproperty
  a_oper_summary: assert property (p_oper_summary)
    else $error("operation summary wrong");

  property p_rise_event;
    $rose(oper_cond_in[gsr_pkg::OPER_CALC_BIT]) && st_reg.rise_filt[gsr_pkg::OPER_CALC_BIT]
      |=> st_reg.oper_event[gsr_pkg::OPER_CALC_BIT];
  endproperty
  a_rise_event: assert property (p_rise_event)
    else $error("rising edge not latched");

  property p_preset;
    reg_cmd.preset |=> st_reg.rise_filt == gsr_pkg::RISE_FILT_RST
      && st_reg.fall_filt == gsr_pkg::FALL_FILT_RST && st_reg.oper_mask == gsr_pkg::ZERO_WORD;
  endproperty
  a_preset: assert property (p_preset)
    else $error("preset did not restore filters");

  property p_mask_read;
    reg_cmd.rd && !reg_cmd.wr && !reg_cmd.preset
      |=> $stable(st_reg.std_mask) && $stable(st_reg.rise_filt);
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("read changed a mask or filter");

  property p_event_survives;
    rd_oper && (oper_hits != gsr_pkg::ZERO_WORD) |=> st_reg.oper_event == $past(oper_hits);
  endproperty
  a_event_survives: assert property (p_event_survives)
    else $error("event lost on read clear");

  property p_listen_on;
    bus_msg.mla && !bus_msg.ifc && !bus_msg.unl && !bus_msg.mta |=> listener_lamp && !talk_lamp;
  endproperty
  a_listen_on: assert property (p_listen_on)
    else $error("listen address did not make listener active");

  property p_std_clear;
    (reg_cmd.cls || rd_std) && (std_hits == gsr_pkg::ZERO_WORD)
      |=> st_reg.std_event == gsr_pkg::ZERO_WORD;
  endproperty
  a_std_clear: assert property (p_std_clear)
    else $error("standard events not cleared");

  property p_oper_clear;
    (reg_cmd.cls || rd_oper) && (oper_hits == gsr_pkg::ZERO_WORD)
      |=> st_reg.oper_event == gsr_pkg::ZERO_WORD;
  endproperty
  a_oper_clear: assert property (p_oper_clear)
    else $error("operation events not cleared");

  property p_oper_hold;
    !reg_cmd.cls && !rd_oper
      |=> (st_reg.oper_event & $past(st_reg.oper_event)) == $past(st_reg.oper_event);
  endproperty
  a_oper_hold: assert property (p_oper_hold)
    else $error("latched operation event lost");

  property p_live_layers;
    operation_condition_live[gsr_pkg::OPER_TRIG_BIT] == trig_summary
      && operation_condition_live[gsr_pkg::OPER_ARM_BIT] == arm_summary;
  endproperty
  a_live_layers: assert property (p_live_layers)
    else $error("layer summaries not in condition word");

  property p_filt_write;
    reg_cmd.wr && !reg_cmd.preset && reg_cmd.sel == gsr_pkg::GSR_SEL_FALL_FILT
      |=> st_reg.fall_filt == $past(reg_cmd.wdata);
  endproperty
  a_filt_write: assert property (p_filt_write)
    else $error("falling filter write lost");

endmodule : gsr_status

// ==== tb/gsr_bus_ctrl.sv ====
// bus controller model: interface messages and register commands
`timescale 1ns/1ps

module gsr_bus_ctrl (
  input wire logic mclk, // instrument clock
  input wire logic [15:0] rdata, // read data from the block
  input wire logic rvalid, // read data valid pulse
  output gsr_pkg::gsr_bus_msg_t bus_msg, // interface messages
  output gsr_pkg::gsr_reg_cmd_t reg_cmd // register commands
);
  // everything idle at time zero
  initial begin
    bus_msg = '0;
    reg_cmd = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // remote enable is a level and holds until changed
  task set_ren(input logic v);
    @(posedge mclk) #1 bus_msg.ren = v;
  endtask : set_ren

  // one-cycle message pulse, ifc mla mta unl unt llo, remote enable untouched
  task pulse(input logic [5:0] m);
    @(posedge mclk) #1 bus_msg[5:0] = m;
    @(posedge mclk) #1 bus_msg[5:0] = 6'h00;
  endtask : pulse

  // clear-status when c is high, status preset otherwise
  task status_cmd(input logic c);
    @(posedge mclk) #1 reg_cmd.cls = c;
    reg_cmd.preset = ~c;
    @(posedge mclk) #1 reg_cmd.cls = 1'b0;
    reg_cmd.preset = 1'b0;
  endtask : status_cmd

  ////////////////////////////////////////////////////////////////////////////
  // register write, held for exactly the taking edge
  task reg_wr(input gsr_pkg::gsr_sel_t s, input logic [15:0] w);
    @(posedge mclk) #1 reg_cmd.sel = s;
    reg_cmd.wdata = w;
    reg_cmd.wr = 1'b1;
    @(posedge mclk) #1 reg_cmd.wr = 1'b0;
  endtask : reg_wr

  // register read, answer taken in the cycle after it stands, from the registered read data
  task reg_rd(input gsr_pkg::gsr_sel_t s, output logic [15:0] d, output logic v);
    @(posedge mclk) #1 reg_cmd.sel = s;
    reg_cmd.rd = 1'b1;
    @(posedge mclk) #1 reg_cmd.rd = 1'b0;
    d = rdata;
    v = rvalid;
  endtask : reg_rd
endmodule : gsr_bus_ctrl

// ==== tb/gsr_status_reporting_test.sv ====
// self-checking bench of the status reporting block
`timescale 1ns/1ps

module gsr_status_reporting_test;
  typedef struct packed {
    gsr_pkg::gsr_sel_t sel;
    logic [15:0] wdata;
    logic [15:0] exp;
  } gsr_row_t;
  localparam logic [5:0] M_IFC = 6'h20, M_MLA = 6'h10, M_MTA = 6'h08;
  localparam logic [5:0] M_UNL = 6'h04, M_UNT = 6'h02, M_LLO = 6'h01;
  logic mclk = 1'b0, nrst = 1'b0, local_key = 1'b0, srq_raised = 1'b0;
  logic srq_causes = 1'b0, spoll_read = 1'b0, empty_queue_read = 1'b0;
  logic trig_summary = 1'b0, arm_summary = 1'b0;
  logic [7:0] panel_keys = 8'h00, panel_keys_out;
  logic [15:0] std_event_in = 16'h0000, oper_cond_in = 16'h0000;
  logic [15:0] operation_condition_live, rdata, d;
  logic host_control_lamp, talk_lamp, listener_lamp, srq_lamp, display_restore;
  logic query_fault_flag, event_summary_flag, operation_summary_flag, rvalid, v;
  gsr_pkg::gsr_bus_msg_t bus_msg;
  gsr_pkg::gsr_reg_cmd_t reg_cmd;
  int err_count = 0, compares = 0;
  // register rows: written value and expected read-back
  gsr_row_t rows [8] = '{'{gsr_pkg::GSR_SEL_STD_MASK, 16'h1234, 16'h1234},
    '{gsr_pkg::GSR_SEL_RISE_FILT, 16'h0000, 16'h0000},
    '{gsr_pkg::GSR_SEL_FALL_FILT, 16'ha5a5, 16'ha5a5},
    '{gsr_pkg::GSR_SEL_OPER_MASK, 16'h0f0f, 16'h0f0f},
    '{gsr_pkg::GSR_SEL_STD_EVENT, 16'hffff, 16'h0000},
    '{gsr_pkg::GSR_SEL_OPER_COND, 16'hffff, 16'h0000},
    '{gsr_pkg::GSR_SEL_OPER_EVENT, 16'hffff, 16'h0000},
    '{gsr_pkg::gsr_sel_t'(3'h7), 16'hffff, 16'h0000}};
  // addressing steps and lamps {host, talk, listen} after each
  logic [5:0] seq_msg [10] = '{M_MLA, M_MTA, M_MLA, M_UNL, M_MTA, M_UNT, M_MLA, M_IFC,
    M_MTA, M_IFC};
  logic [2:0] seq_lamp [10] = '{3'h5, 3'h6, 3'h5, 3'h4, 3'h6, 3'h4, 3'h5, 3'h4, 3'h6, 3'h4};

  // 20 MHz clock
  always #25 mclk = ~mclk;

  gsr_bus_ctrl ctrl (.mclk, .rdata, .rvalid, .bus_msg, .reg_cmd);

  gsr_status dut (.mclk, .nrst, .bus_msg, .panel_keys, .local_key, .srq_raised, .srq_causes,
    .spoll_read, .std_event_in, .empty_queue_read, .oper_cond_in, .trig_summary, .arm_summary,
    .reg_cmd, .host_control_lamp, .talk_lamp, .listener_lamp, .srq_lamp, .panel_keys_out,
    .display_restore, .query_fault_flag, .event_summary_flag, .operation_summary_flag,
    .operation_condition_live, .rdata, .rvalid);

  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // read one register and compare the answer
  task automatic rd_chk(input gsr_pkg::gsr_sel_t s, input logic [15:0] e);
    logic [15:0] g;
    logic ok;
    ctrl.reg_rd(s, g, ok);
    chk("rvalid", 16'h0001, 16'(ok));
    chk("rdata", e, g);
  endtask : rd_chk

  // one-cycle strobe of a bench input
  task automatic tick(ref logic s);
    @(posedge mclk) #1 s = 1'b1;
    @(posedge mclk) #1 s = 1'b0;
  endtask : tick

  // counts, verdict and end of run
  task give_verdict;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  // hang guard
  initial begin
    #3000000;
    err_count++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (4) @(posedge mclk);
    #1 nrst = 1'b1;
    rd_chk(gsr_pkg::GSR_SEL_RISE_FILT, 16'hffff);
    rd_chk(gsr_pkg::GSR_SEL_FALL_FILT, 16'h0000);
    rd_chk(gsr_pkg::GSR_SEL_STD_MASK, 16'h0000);
    rd_chk(gsr_pkg::GSR_SEL_OPER_MASK, 16'h0000);
    rd_chk(gsr_pkg::GSR_SEL_STD_EVENT, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      ctrl.reg_wr(rows[i].sel, rows[i].wdata);
      rd_chk(rows[i].sel, rows[i].exp);
      rd_chk(rows[i].sel, rows[i].exp);
    end
    ctrl.status_cmd(1'b0);
    rd_chk(gsr_pkg::GSR_SEL_RISE_FILT, 16'hffff);
    rd_chk(gsr_pkg::GSR_SEL_FALL_FILT, 16'h0000);
    rd_chk(gsr_pkg::GSR_SEL_OPER_MASK, 16'h0000);
    rd_chk(gsr_pkg::GSR_SEL_STD_MASK, 16'h1234);
    // addressing and lamps
    ctrl.set_ren(1'b1);
    @(posedge mclk) #1;
    chk("remote", 16'h0000, 16'(host_control_lamp));
    for (int i = 0; i < 10; i++) begin
      ctrl.pulse(seq_msg[i]);
      chk("lamps", 16'(seq_lamp[i]), 16'({host_control_lamp, talk_lamp, listener_lamp}));
    end
    panel_keys = 8'hff;
    #1 chk("keys", 16'h0000, 16'(panel_keys_out));
    tick(local_key);
    chk("restore", 16'h0001, 16'(display_restore));
    chk("remote", 16'h0000, 16'(host_control_lamp));
    chk("keys", 16'h00ff, 16'(panel_keys_out));
    ctrl.pulse(M_MLA);
    ctrl.pulse(M_LLO);
    tick(local_key);
    chk("restore", 16'h0000, 16'(display_restore));
    chk("remote", 16'h0001, 16'(host_control_lamp));
    ctrl.set_ren(1'b0);
    // service request lamp
    srq_causes = 1'b1;
    tick(srq_raised);
    repeat (3) @(posedge mclk);
    #1 chk("srq", 16'h0001, 16'(srq_lamp));
    tick(spoll_read);
    chk("srq", 16'h0000, 16'(srq_lamp));
    tick(srq_raised);
    srq_causes = 1'b0;
    @(posedge mclk) #1 chk("srq", 16'h0000, 16'(srq_lamp));
    // standard events
    tick(empty_queue_read);
    chk("query", 16'h0001, 16'(query_fault_flag));
    chk("event_summary", 16'h0001, 16'(event_summary_flag));
    ctrl.reg_wr(gsr_pkg::GSR_SEL_STD_MASK, 16'h0000);
    @(posedge mclk) #1 chk("event_summary", 16'h0000, 16'(event_summary_flag));
    @(posedge mclk) #1 std_event_in = 16'hffff;
    @(posedge mclk) #1 std_event_in = 16'h0000;
    rd_chk(gsr_pkg::GSR_SEL_STD_EVENT, 16'hfffd);
    rd_chk(gsr_pkg::GSR_SEL_STD_EVENT, 16'h0000);
    @(posedge mclk) #1 std_event_in = 16'h0080;
    @(posedge mclk) #1 std_event_in = 16'h0000;
    ctrl.status_cmd(1'b1);
    rd_chk(gsr_pkg::GSR_SEL_STD_EVENT, 16'h0000);
    // operation events
    ctrl.reg_wr(gsr_pkg::GSR_SEL_OPER_MASK, 16'h0200);
    @(posedge mclk) #1 oper_cond_in = 16'h0260;
    @(posedge mclk) #1 chk("live", 16'h0200, operation_condition_live);
    chk("operation_summary", 16'h0001, 16'(operation_summary_flag));
    trig_summary = 1'b1;
    arm_summary = 1'b1;
    @(posedge mclk) #1 chk("live", 16'h0260, operation_condition_live);
    rd_chk(gsr_pkg::GSR_SEL_OPER_EVENT, 16'h0260);
    rd_chk(gsr_pkg::GSR_SEL_OPER_EVENT, 16'h0000);
    chk("operation_summary", 16'h0000, 16'(operation_summary_flag));
    ctrl.reg_wr(gsr_pkg::GSR_SEL_RISE_FILT, 16'h0008);
    ctrl.reg_wr(gsr_pkg::GSR_SEL_FALL_FILT, 16'h0200);
    @(posedge mclk) #1 oper_cond_in = 16'h0000;
    trig_summary = 1'b0;
    arm_summary = 1'b0;
    rd_chk(gsr_pkg::GSR_SEL_OPER_EVENT, 16'h0200);
    // new event on the same edge as the clearing read
    fork
      ctrl.reg_rd(gsr_pkg::GSR_SEL_OPER_EVENT, d, v);
      @(posedge mclk) #1 oper_cond_in = 16'h0008;
    join
    chk("rdata", 16'h0000, d);
    rd_chk(gsr_pkg::GSR_SEL_OPER_EVENT, 16'h0008);
    // mid-run reset brings back the power-up register values
    ctrl.reg_wr(gsr_pkg::GSR_SEL_STD_MASK, 16'h00ff);
    @(posedge mclk) #1 nrst = 1'b0;
    @(posedge mclk) #1 nrst = 1'b1;
    rd_chk(gsr_pkg::GSR_SEL_STD_MASK, 16'h0000);
    rd_chk(gsr_pkg::GSR_SEL_RISE_FILT, 16'hffff);
    rd_chk(gsr_pkg::GSR_SEL_FALL_FILT, 16'h0000);
    rd_chk(gsr_pkg::GSR_SEL_OPER_MASK, 16'h0000);
    give_verdict();
  end
endmodule : gsr_status_reporting_test
